// >>> logic/pds_access.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Word low table read returns bits 15:0
// - Byte low table read selects byte
// - Word high table read zero extends
// - Byte high read: upper byte or zero
// - Program address steps two per word
// - Window never exposes upper program byte
// - Upper data half maps one page
// - Redirect only if bit15 and enable
// - Low 15 bits plus page form address
// - Window read returns low sixteen bits
// - No window during table operations
// - Outside repeat: one or two cycles
// - Repeat: two on first, last or interrupt iteration, none otherwise
// - MAC reads exclude Y from X
// - MAC pointers fixed to their spaces
// - All writes use the X bus
// - Y path only for MAC prefetch
// - Bit reverse on X writes only
// - X/Y boundary fixed in hardware
// - Invalid reads return zero
// - Sixteen bit byte addresses
// - Byte reads pick by address bit0
// - Table page top bit picks space
module pds_access #(
  parameter int PAW = 12,
  parameter int DAW = 11
) (
  input  wire logic            clk_sys_i,
  input  wire logic            reset_i,
  input  wire logic [7:0]      paddr_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire pds_pkg::req_s   req_i,
  input  wire logic            bitrev_i,
  output pds_pkg::rsp_s        rsp_o,
  output logic                 stall_o,
  input  wire logic            pm_we_i,
  input  wire logic [PAW-1:0]  pm_waddr_i,
  input  wire logic [23:0]     pm_wdata_i,
  output logic      [23:0]     prog_addr_o,
  output logic                 cfg_space_o
);
  if (PAW < 4 || PAW > 22 || DAW < 4 || DAW > 15) begin : g_bad_width
    $error("pds_access width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic        window_en;
  logic [7:0]  window_page_reg;
  logic [7:0]  table_page_reg;
  logic [15:0] stall_count;
  logic        last_invalid;
  logic        last_win;
  logic        apb_access;

  assign apb_access = psel_i && penable_i;
  assign pready_o   = 1'b1;

  function automatic logic known_off(input logic [7:0] a);
    return a == pds_pkg::OFF_CTRL || a == pds_pkg::OFF_WPAGE ||
           a == pds_pkg::OFF_TPAGE || a == pds_pkg::OFF_STATUS ||
           a == pds_pkg::OFF_STALLCNT;
  endfunction : known_off

  assign pslverr_o = apb_access && !known_off(paddr_i);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      window_en       <= pds_pkg::RST_WINDOW_EN;
      window_page_reg <= pds_pkg::RST_WPAGE;
      table_page_reg  <= pds_pkg::RST_TPAGE;
    end else if (apb_access && pwrite_i) begin
      if (paddr_i == pds_pkg::OFF_CTRL) begin
        window_en <= pwdata_i[pds_pkg::CTRL_WINDOW_EN_BIT];
      end else if (paddr_i == pds_pkg::OFF_WPAGE) begin
        window_page_reg <= pwdata_i[7:0];
      end else if (paddr_i == pds_pkg::OFF_TPAGE) begin
        table_page_reg <= pwdata_i[7:0];
      end
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (paddr_i == pds_pkg::OFF_CTRL) begin
      prdata_o[pds_pkg::CTRL_WINDOW_EN_BIT] = window_en;
    end else if (paddr_i == pds_pkg::OFF_WPAGE) begin
      prdata_o[7:0] = window_page_reg;
    end else if (paddr_i == pds_pkg::OFF_TPAGE) begin
      prdata_o[7:0] = table_page_reg;
    end else if (paddr_i == pds_pkg::OFF_STATUS) begin
      prdata_o[pds_pkg::STAT_STALL_BIT]   = stall_o;
      prdata_o[pds_pkg::STAT_WINACC_BIT]  = last_win;
      prdata_o[pds_pkg::STAT_INVALID_BIT] = last_invalid;
    end else if (paddr_i == pds_pkg::OFF_STALLCNT) begin
      prdata_o[15:0] = stall_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic in_y(input logic [15:0] a);
    return a >= pds_pkg::Y_BASE && a <= pds_pkg::Y_LAST;
  endfunction : in_y

  function automatic logic implemented(input logic [15:0] a);
    return a <= pds_pkg::IMPL_LAST;
  endfunction : implemented

  function automatic logic [15:0] bit_reverse(input logic [15:0] a);
    logic [15:0] r;
    r = '0;
    for (int i = 1; i < 16; i++) begin
      r[i] = a[16-i];
    end
    return r;
  endfunction : bit_reverse

  logic       is_table;
  logic       is_mac;
  logic       win_hit;
  logic       x_invalid;
  logic       y_invalid;
  logic [15:0] x_ea;

  assign is_table = req_i.op == pds_pkg::OP_TABLE_READ_LOW ||
                    req_i.op == pds_pkg::OP_TABLE_READ_HIGH ||
                    req_i.op == pds_pkg::OP_TABLE_WRITE;
  assign is_mac   = req_i.op == pds_pkg::OP_MAC_PREFETCH;

  // Window needs bit15, enable, and no table operation
  assign win_hit = req_i.valid && req_i.ea[15] && window_en &&
                   !is_table;

  // Bit reversal only on X writes
  assign x_ea = (bitrev_i && req_i.op == pds_pkg::OP_DATA_WRITE) ?
                bit_reverse(req_i.ea) : req_i.ea;

  // MAC reads: X excludes Y block, Y path only Y block
  assign x_invalid = (!win_hit && !is_table && !implemented(req_i.ea)) ||
                     (is_mac && in_y(req_i.ea));
  assign y_invalid = is_mac && !in_y(req_i.y_ea);

  ////////////////////////////////////////////////////////////////////////////
  // Program address
  logic [23:0] next_prog_addr;

  always_comb begin
    next_prog_addr = '0;
    if (is_table) begin
      next_prog_addr = {table_page_reg, req_i.ea};
    end else if (win_hit) begin
      next_prog_addr = {1'b0, window_page_reg,
                        req_i.ea[14:0]};
    end
  end

  assign cfg_space_o = is_table && table_page_reg[pds_pkg::TPAGE_CFG_BIT];

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prog_addr_o <= '0;
    end else if (req_i.valid) begin
      prog_addr_o <= next_prog_addr;
    end
  end

  // One memory word per two address units
  logic [23:0] pm_rdata;
  pds_prog_mem #(.AW(PAW)) u_prog (
    .clk_sys_i (clk_sys_i),
    .raddr_i   (next_prog_addr[PAW:1]),
    .we_i      (pm_we_i),
    .waddr_i   (pm_waddr_i),
    .wdata_i   (pm_wdata_i),
    .rdata_o   (pm_rdata)
  );

  logic [1:0]  dm_we;
  logic [15:0] dm_xr;
  logic [15:0] dm_yr;
  logic        wr_ok;

  assign wr_ok = req_i.valid && req_i.op == pds_pkg::OP_DATA_WRITE &&
                 !win_hit && implemented(x_ea);
  // Writes only over X, lane by byte address
  assign dm_we = !wr_ok ? 2'b00 :
                 !req_i.byte_op ? 2'b11 :
                 (x_ea[0] ? 2'b10 : 2'b01);

  pds_data_mem #(.AW(DAW)) u_data (
    .clk_sys_i (clk_sys_i),
    .xaddr_i   (x_ea[DAW:1]),
    .yaddr_i   (req_i.y_ea[DAW:1]),
    .we_i      (dm_we),
    .wdata_i   (req_i.byte_op ? {2{req_i.wdata[7:0]}} : req_i.wdata),
    .xrdata_o  (dm_xr),
    .yrdata_o  (dm_yr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stall sequencing
  pds_pkg::state_e state;
  logic [1:0] add_cycles;
  logic [1:0] wait_cnt;

  always_comb begin
    add_cycles = pds_pkg::WIN_ADD_LONG;
    if (req_i.in_repeat) begin
      if (!(req_i.rep_first || req_i.rep_last || req_i.rep_irq)) begin
        add_cycles = 2'h0;
      end
    end else if (req_i.cls != pds_pkg::CLS_OTHER) begin
      add_cycles = pds_pkg::WIN_ADD_SHORT;
    end
  end

  assign stall_o = state == pds_pkg::ST_STALL;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= pds_pkg::ST_IDLE;
      wait_cnt <= 2'h0;
    end else begin
      case (state)
        pds_pkg::ST_IDLE: begin
          if (win_hit && add_cycles != 2'h0) begin
            state    <= pds_pkg::ST_STALL;
            wait_cnt <= add_cycles - 2'h1;
          end
        end
        pds_pkg::ST_STALL: begin
          if (wait_cnt == 2'h0) begin
            state <= pds_pkg::ST_DONE;
          end else begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        end
        pds_pkg::ST_DONE: begin
          state <= pds_pkg::ST_IDLE;
        end
        default: begin
          state <= pds_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      stall_count <= 16'h0000;
    end else if (stall_o) begin
      stall_count <= stall_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read steering, one cycle after request
  logic        p_valid;
  pds_pkg::op_e p_op;
  logic        p_byte;
  logic        p_bsel;
  logic        p_win;
  logic        p_xinv;
  logic        p_yinv;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      p_valid <= 1'b0;
      p_op    <= pds_pkg::OP_DATA_READ;
      p_byte  <= 1'b0;
      p_bsel  <= 1'b0;
      p_win   <= 1'b0;
      p_xinv  <= 1'b0;
      p_yinv  <= 1'b0;
    end else begin
      p_valid <= req_i.valid && req_i.op != pds_pkg::OP_DATA_WRITE &&
                 req_i.op != pds_pkg::OP_TABLE_WRITE;
      p_op    <= req_i.op;
      p_byte  <= req_i.byte_op;
      p_bsel  <= req_i.ea[0];
      p_win   <= win_hit;
      p_xinv  <= x_invalid;
      p_yinv  <= y_invalid;
    end
  end

  function automatic logic [15:0] pick_byte(input logic [15:0] w,
                                            input logic sel);
    return {8'h00, sel ? w[15:8] : w[7:0]};
  endfunction : pick_byte

  logic [15:0] next_x;
  logic [15:0] next_y;

  always_comb begin
    next_x = pds_pkg::ZERO_WORD;
    next_y = pds_pkg::ZERO_WORD;
    if (p_op == pds_pkg::OP_TABLE_READ_LOW) begin
      next_x = p_byte ? pick_byte(pm_rdata[15:0], p_bsel)
                      : pm_rdata[15:0];
    end else if (p_op == pds_pkg::OP_TABLE_READ_HIGH) begin
      next_x = p_byte ? pick_byte({8'h00, pm_rdata[23:16]}, p_bsel)
                      : {8'h00, pm_rdata[23:16]};
    end else if (p_win) begin
      next_x = p_byte ? pick_byte(pm_rdata[15:0], p_bsel)
                      : pm_rdata[15:0];
    end else if (!p_xinv) begin
      next_x = p_byte ? pick_byte(dm_xr, p_bsel) : dm_xr;
    end
    if (p_op == pds_pkg::OP_MAC_PREFETCH && !p_yinv) begin
      next_y = dm_yr;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_o        <= '0;
      last_invalid <= 1'b0;
      last_win     <= 1'b0;
    end else begin
      rsp_o.valid  <= p_valid;
      rsp_o.xdata  <= next_x;
      rsp_o.ydata  <= next_y;
      if (p_valid) begin
        last_invalid <= p_xinv || p_yinv;
        last_win     <= p_win;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_zero_invalid;
    @(posedge clk_sys_i) disable iff (reset_i)
      (p_valid && p_xinv && !p_win &&
       p_op == pds_pkg::OP_MAC_PREFETCH) |=> rsp_o.xdata == 16'h0000;
  endproperty
  a_zero_invalid: assert property (p_zero_invalid)
    else $error("invalid read not zero");

  property p_high_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
      (p_valid && p_op == pds_pkg::OP_TABLE_READ_HIGH) |=>
        rsp_o.xdata[15:8] == 8'h00;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("high table read upper byte not zero");

  property p_low_word;
    @(posedge clk_sys_i) disable iff (reset_i)
      (p_valid && p_op == pds_pkg::OP_TABLE_READ_LOW && !p_byte) |=>
        rsp_o.xdata == $past(pm_rdata[15:0]);
  endproperty
  a_low_word: assert property (p_low_word)
    else $error("low table word mismatch");

  sequence s_win_long;
    state == pds_pkg::ST_IDLE && win_hit && !req_i.in_repeat &&
      req_i.cls == pds_pkg::CLS_OTHER;
  endsequence
  property p_two_stalls;
    @(posedge clk_sys_i) disable iff (reset_i)
      s_win_long |=> stall_o [*2] ##1 !stall_o;
  endproperty
  a_two_stalls: assert property (p_two_stalls)
    else $error("window stall length wrong");

  property p_rep_mid;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state == pds_pkg::ST_IDLE && win_hit && req_i.in_repeat &&
       !req_i.rep_first && !req_i.rep_last && !req_i.rep_irq) |=> !stall_o;
  endproperty
  a_rep_mid: assert property (p_rep_mid)
    else $error("mid repeat stalled");

  property p_no_win_table;
    @(posedge clk_sys_i) disable iff (reset_i)
      (req_i.valid && is_table && state == pds_pkg::ST_IDLE) |=>
        !stall_o && prog_addr_o[15:0] == $past(req_i.ea);
  endproperty
  a_no_win_table: assert property (p_no_win_table)
    else $error("window during table op");

  property p_page;
    @(posedge clk_sys_i) disable iff (reset_i)
      win_hit |=> prog_addr_o[14:0] == $past(req_i.ea[14:0]) &&
                  prog_addr_o[23] == 1'b0;
  endproperty
  a_page: assert property (p_page)
    else $error("window address wrong");

  property p_write_x;
    @(posedge clk_sys_i) disable iff (reset_i)
      (dm_we != 2'b00) |-> req_i.op == pds_pkg::OP_DATA_WRITE;
  endproperty
  a_write_x: assert property (p_write_x)
    else $error("write by non-write op");
endmodule : pds_access

// >>> logic/pds_pkg.sv
package pds_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_WPAGE    = 8'h04;
  localparam logic [7:0] OFF_TPAGE    = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_STALLCNT = 8'h10;

  // Field positions
  localparam int CTRL_WINDOW_EN_BIT = 0;
  localparam int STAT_STALL_BIT     = 0;
  localparam int STAT_WINACC_BIT    = 1;
  localparam int STAT_INVALID_BIT   = 2;
  localparam int TPAGE_CFG_BIT      = 7;

  // Reset values
  localparam logic        RST_WINDOW_EN = 1'b0;
  localparam logic [7:0]  RST_WPAGE     = 8'h00;
  localparam logic [7:0]  RST_TPAGE     = 8'h00;

  // Address map, fixed in hardware
  localparam logic [15:0] WINDOW_BASE   = 16'h8000;
  localparam logic [15:0] Y_BASE        = 16'h0800;
  localparam logic [15:0] Y_LAST        = 16'h0FFF;
  localparam logic [15:0] IMPL_LAST     = 16'h0FFF;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  // Extra window cycles
  localparam logic [1:0]  WIN_ADD_SHORT = 2'h1;
  localparam logic [1:0]  WIN_ADD_LONG  = 2'h2;

  // Operation codes from the core
  typedef enum logic [2:0] {
    OP_DATA_READ       = 3'h0,
    OP_DATA_WRITE      = 3'h1,
    OP_TABLE_READ_LOW  = 3'h2,
    OP_TABLE_READ_HIGH = 3'h3,
    OP_TABLE_WRITE     = 3'h4,
    OP_MAC_PREFETCH    = 3'h5
  } op_e;

  // Instruction class for cycle cost
  typedef enum logic [1:0] {
    CLS_OTHER = 2'h0,
    CLS_MAC   = 2'h1,
    CLS_MOVE  = 2'h2,
    CLS_DMOVE = 2'h3
  } cls_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_STALL = 3'b010,
    ST_DONE  = 3'b100
  } state_e;

  typedef struct packed {
    logic        valid;
    op_e         op;
    cls_e        cls;
    logic        byte_op;
    logic [15:0] ea;
    logic [15:0] y_ea;
    logic [1:0]  x_ptr_sel;
    logic [1:0]  y_ptr_sel;
    logic        in_repeat;
    logic        rep_first;
    logic        rep_last;
    logic        rep_irq;
    logic [15:0] wdata;
  } req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] xdata;
    logic [15:0] ydata;
  } rsp_s;

endpackage : pds_pkg

// >>> logic/pds_prog_mem.sv
`timescale 1ns/1ps
module pds_prog_mem #(
  parameter int AW = 12
) (
  input  wire logic          clk_sys_i,
  input  wire logic [AW-1:0] raddr_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [23:0]   wdata_i,
  output logic      [23:0]   rdata_o
);
  if (AW < 4 || AW > 22) begin : g_bad_aw
    $error("pds_prog_mem AW out of range");
  end

  logic [23:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : pds_prog_mem

// >>> logic/pds_data_mem.sv
`timescale 1ns/1ps
module pds_data_mem #(
  parameter int AW = 11
) (
  input  wire logic          clk_sys_i,
  input  wire logic [AW-1:0] xaddr_i,
  input  wire logic [AW-1:0] yaddr_i,
  input  wire logic [1:0]    we_i,
  input  wire logic [15:0]   wdata_i,
  output logic      [15:0]   xrdata_o,
  output logic      [15:0]   yrdata_o
);
  if (AW < 4 || AW > 15) begin : g_bad_aw
    $error("pds_data_mem AW out of range");
  end

  logic [7:0] lo [0:(1<<AW)-1];
  logic [7:0] hi [0:(1<<AW)-1];

  // Byte lanes written separately
  always_ff @(posedge clk_sys_i) begin
    if (we_i[0]) begin
      lo[xaddr_i] <= wdata_i[7:0];
    end
    if (we_i[1]) begin
      hi[xaddr_i] <= wdata_i[15:8];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    xrdata_o <= {hi[xaddr_i], lo[xaddr_i]};
    yrdata_o <= {hi[yaddr_i], lo[yaddr_i]};
  end
endmodule : pds_data_mem

// >>> bench/pds_core_model.sv
`timescale 1ns/1ps
module pds_core_model (
  input  wire logic          clk_sys_i,
  input  wire logic          stall_i,
  input  wire pds_pkg::rsp_s rsp_i,
  output pds_pkg::req_s      req_o
);
  initial req_o = '0;

  ////////////////////////////////////////////////////////////////////////////
  // One request, then watch eight cycles for answer and stalls
  task automatic issue(input pds_pkg::req_s r, output logic [15:0] x,
                       output logic [15:0] y, output int stalls);
    pds_pkg::req_s idle;
    logic          got;
    idle       = pds_pkg::req_s'(~r);
    idle.valid = 1'b0;
    got        = 1'b0;
    x          = 'x;
    y          = 'x;
    stalls     = 0;
    @(posedge clk_sys_i);
    req_o <= r;
    @(posedge clk_sys_i);
    req_o <= idle;
    // Eight quiet cycles cover the stall and the hold-off after it
    repeat (8) begin
      #1;
      if (stall_i === 1'b1) stalls++;
      if (rsp_i.valid === 1'b1 && !got) begin
        x   = rsp_i.xdata;
        y   = rsp_i.ydata;
        got = 1'b1;
      end
      @(posedge clk_sys_i);
    end
  endtask : issue
endmodule : pds_core_model

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                clk_sys_i, reset_i, psel, penable, pwrite;
  logic                pready, pslverr, bitrev, stall, pm_we, cfg_space;
  logic                cfg_seen;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  logic [11:0]         pm_waddr;
  logic [23:0]         pm_wdata, prog_addr;
  pds_pkg::req_s       req;
  pds_pkg::rsp_s       rsp;
  pds_pkg::req_s       r;
  int                  err_total, checks_done;

  pds_access #(.PAW(12), .DAW(11)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .req_i(req), .bitrev_i(bitrev), .rsp_o(rsp),
    .stall_o(stall), .pm_we_i(pm_we), .pm_waddr_i(pm_waddr),
    .pm_wdata_i(pm_wdata), .prog_addr_o(prog_addr),
    .cfg_space_o(cfg_space)
  );

  pds_core_model i_core (
    .clk_sys_i(clk_sys_i), .stall_i(stall), .rsp_i(rsp), .req_o(req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic do_reset;
    reset_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask : do_reset

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(what, rd, exp);
    check({what, " error"}, {31'h0, err}, {31'h0, exp_err});
  endtask : rd_chk

  task automatic pm_load(input logic [11:0] i, input logic [23:0] d);
    @(posedge clk_sys_i);
    pm_we    <= 1'b1;
    pm_waddr <= i;
    pm_wdata <= d;
    @(posedge clk_sys_i);
    pm_we    <= 1'b0;
  endtask : pm_load

  function automatic pds_pkg::req_s mk(pds_pkg::op_e op, pds_pkg::cls_e c,
      logic b, logic [15:0] ea, logic [15:0] y_ea, logic [15:0] wd);
    mk = '{valid: 1'b1, op: op, cls: c, byte_op: b, ea: ea, y_ea: y_ea,
           wdata: wd, default: '0};
  endfunction : mk

  task automatic run(input string what, input pds_pkg::req_s q,
                     input logic [15:0] ex, ey, input int es);
    logic [15:0] x, y;
    int          n;
    i_core.issue(q, x, y, n);
    if (q.op != pds_pkg::OP_DATA_WRITE) check({what, " x"}, x, ex);
    if (q.op == pds_pkg::OP_MAC_PREFETCH) check({what, " y"}, y, ey);
    check({what, " stall"}, n, es);
  endtask : run

  task automatic tbl(input logic hi, b, input logic [15:0] ea, ex);
    run("table", mk(hi ? pds_pkg::OP_TABLE_READ_HIGH
                       : pds_pkg::OP_TABLE_READ_LOW,
                    pds_pkg::CLS_OTHER, b, ea, 16'h0, 16'h0), ex, 16'h0, 0);
  endtask : tbl

  task automatic drd(input pds_pkg::op_e op, input pds_pkg::cls_e c,
                     input logic b, input logic [15:0] ea, y_ea, wd, ex,
                     ey, input int es);
    run("data", mk(op, c, b, ea, y_ea, wd), ex, ey, es);
  endtask : drd

  // Space select seen with each request
  always @(posedge clk_sys_i) begin
    if (req.valid) cfg_seen <= cfg_space;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #80000;
    err_total++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    reset_i = 1'b1;
    {psel, penable, pwrite, bitrev, pm_we} = '0;
    {paddr, pwdata, pm_waddr, pm_wdata} = '0;
    err_total = 0;
    checks_done = 0;
    do_reset();
    rd_chk("ctrl reset", pds_pkg::OFF_CTRL, 32'h0, 1'b0);
    rd_chk("wpage reset", pds_pkg::OFF_WPAGE, 32'h0, 1'b0);
    rd_chk("tpage reset", pds_pkg::OFF_TPAGE, 32'h0, 1'b0);
    rd_chk("unmapped", 8'h14, 32'h0, 1'b1);
    wr(pds_pkg::OFF_WPAGE, 32'h0000_01A5);
    rd_chk("wpage", pds_pkg::OFF_WPAGE, 32'h0000_00A5, 1'b0);
    $display("test registers done");
    pm_load(12'h002, 24'h5AB3C4);
    pm_load(12'h003, 24'h81F00D);
    tbl(1'b0, 1'b0, 16'h0004, 16'hB3C4);
    tbl(1'b0, 1'b1, 16'h0004, 16'h00C4);
    tbl(1'b0, 1'b1, 16'h0005, 16'h00B3);
    tbl(1'b1, 1'b0, 16'h0004, 16'h005A);
    tbl(1'b1, 1'b1, 16'h0004, 16'h005A);
    tbl(1'b1, 1'b1, 16'h0005, 16'h0000);
    tbl(1'b0, 1'b0, 16'h0006, 16'hF00D);
    check("table address", prog_addr, 24'h000006);
    $display("test table reads done");
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h8004, 16'h0,
        16'h0, 16'h0000, 16'h0, 0);
    wr(pds_pkg::OFF_CTRL, 32'h1);
    wr(pds_pkg::OFF_WPAGE, 32'h3);
    for (int c = 0; c < 4; c++) begin
      drd(pds_pkg::OP_DATA_READ, pds_pkg::cls_e'(c), 1'b0, 16'h8004, 16'h0,
          16'h0, 16'hB3C4, 16'h0, (c == 0) ? 2 : 1);
    end
    check("window address", prog_addr, 24'h018004);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b1, 16'h8005, 16'h0,
        16'h0, 16'h00B3, 16'h0, 2);
    for (int k = 0; k < 4; k++) begin
      r = mk(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h8004,
             16'h0, 16'h0);
      r.in_repeat = 1'b1;
      r.rep_first = (k == 0);
      r.rep_last  = (k == 2);
      r.rep_irq   = (k == 3);
      run("repeat", r, 16'hB3C4, 16'h0, (k == 1) ? 0 : 2);
    end
    tbl(1'b0, 1'b0, 16'h8004, 16'hB3C4);
    check("table in window", prog_addr, 24'h008004);
    check("user space", cfg_seen, 1'b0);
    wr(pds_pkg::OFF_TPAGE, 32'h80);
    tbl(1'b0, 1'b0, 16'h0004, 16'hB3C4);
    check("config address", prog_addr, 24'h800004);
    check("config space", cfg_seen, 1'b1);
    rd_chk("stall count", pds_pkg::OFF_STALLCNT, 32'hD, 1'b0);
    $display("test window done");
    drd(pds_pkg::OP_DATA_WRITE, pds_pkg::CLS_OTHER, 1'b0, 16'h0010, 16'h0,
        16'h1234, 16'h0, 16'h0, 0);
    drd(pds_pkg::OP_DATA_WRITE, pds_pkg::CLS_MAC, 1'b0, 16'h0810, 16'h0,
        16'hBEEF, 16'h0, 16'h0, 0);
    drd(pds_pkg::OP_DATA_WRITE, pds_pkg::CLS_OTHER, 1'b1, 16'h0011, 16'h0,
        16'hABAB, 16'h0, 16'h0, 0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h0010, 16'h0,
        16'h0, 16'hAB34, 16'h0, 0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h0810, 16'h0,
        16'h0, 16'hBEEF, 16'h0, 0);
    drd(pds_pkg::OP_MAC_PREFETCH, pds_pkg::CLS_MAC, 1'b0, 16'h0010,
        16'h0810, 16'h0, 16'hAB34, 16'hBEEF, 0);
    drd(pds_pkg::OP_MAC_PREFETCH, pds_pkg::CLS_MAC, 1'b0, 16'h0810,
        16'h0010, 16'h0, 16'h0000, 16'h0000, 0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h2000, 16'h0,
        16'h0, 16'h0000, 16'h0, 0);
    rd_chk("status", pds_pkg::OFF_STATUS, 32'h4, 1'b0);
    bitrev <= 1'b1;
    drd(pds_pkg::OP_DATA_WRITE, pds_pkg::CLS_OTHER, 1'b0, 16'h2000, 16'h0,
        16'h5A5A, 16'h0, 16'h0, 0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h0010, 16'h0,
        16'h0, 16'hAB34, 16'h0, 0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_OTHER, 1'b0, 16'h0008, 16'h0,
        16'h0, 16'h5A5A, 16'h0, 0);
    bitrev <= 1'b0;
    $display("test data spaces done");
    do_reset();
    rd_chk("ctrl again", pds_pkg::OFF_CTRL, 32'h0, 1'b0);
    rd_chk("tpage again", pds_pkg::OFF_TPAGE, 32'h0, 1'b0);
    drd(pds_pkg::OP_DATA_READ, pds_pkg::CLS_MAC, 1'b0, 16'h0810, 16'h0,
        16'h0, 16'hBEEF, 16'h0, 0);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb
